// File: src/nvhbd_top.sv
`include "nvhbd_params.svh"
`timescale 1ns/100ps
`default_nettype none
module nvhbd_top
  import nvhbd_pkg::*;
#(
  parameter int REC_CYCLES = `NVHBD_REC_CYCLES
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic chip_en_n,
  input wire logic out_en_n,
  input wire logic wr_en_n,
  input wire logic [`NVHBD_ADDR_W-1:0] addr,
  input wire logic [7:0] data_bus_bits_in,
  output logic [7:0] data_bus_bits_out,
  output logic data_bus_bits_oe_n,
  output logic ext_ram_select_n,
  output logic ext_ram_read_strobe_n,
  output logic rst_out_n,
  output logic rst_out_oe_n
);
  // ****************************************
  // Checks
  // ****************************************
  initial begin
    if (REC_CYCLES < 1) begin
      $error("REC_CYCLES must be at least one");
    end
    // A longer count would hold the host in reset past its guaranteed limit.
    if (REC_CYCLES > `NVHBD_REC_MAX_CYCLES) begin
      $error("REC_CYCLES exceeds the longest allowed recovery");
    end
  end

  // ****************************************
  // Power supervision
  // ****************************************
  // Recovery counts the minimum time; it stays well inside the maximum.
  nvhbd_pwr_t pwr_reg;
  nvhbd_pwr_t pwr_next;
  logic [31:0] rec_cnt_reg;
  logic [31:0] rec_cnt_next;
  wire logic rec_done = (rec_cnt_reg >= 32'(REC_CYCLES - 1));
  wire logic powered = (pwr_reg == NVHBD_RUN);

  always_comb begin
    pwr_next = pwr_reg;
    rec_cnt_next = 32'h0;
    case (pwr_reg)
      NVHBD_OFF: begin
        if (supply_ok) begin
          pwr_next = NVHBD_REC;
        end
      end
      NVHBD_REC: begin
        if (!supply_ok) begin
          pwr_next = NVHBD_OFF;
        end else if (rec_done) begin
          pwr_next = NVHBD_RUN;
        end else begin
          rec_cnt_next = rec_cnt_reg + 32'h1;
        end
      end
      NVHBD_RUN: begin
        if (!supply_ok) begin
          pwr_next = NVHBD_OFF;
        end
      end
      default: pwr_next = NVHBD_OFF;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pwr_reg <= NVHBD_OFF;
      rec_cnt_reg <= 32'h0;
    end else begin
      pwr_reg <= pwr_next;
      rec_cnt_reg <= rec_cnt_next;
    end
  end

  // ****************************************
  // Strobe decode
  // ****************************************
  wire logic sel = powered && !chip_en_n;
  wire logic in_regs = ((addr & `NVHBD_REG_MASK) == `NVHBD_REG_BASE);
  wire logic rd_cyc = sel && wr_en_n;
  wire logic wr_cyc = sel && !wr_en_n;
  wire logic reg_rd = rd_cyc && !out_en_n && in_regs;
  wire logic ram_rd = rd_cyc && !out_en_n && !in_regs;
  logic wr_d_reg;

  // ****************************************
  // Clock register file
  // ****************************************
  logic [7:0] regs_reg [16];
  // The byte is taken at the trailing edge, where host data is settled.
  wire logic wr_end = wr_d_reg && !wr_cyc;
  logic [`NVHBD_ADDR_W-1:0] wr_addr_reg;
  logic [7:0] wr_data_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_d_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= `NVHBD_REG_RST;
    end else begin
      wr_d_reg <= wr_cyc;
      if (wr_cyc) begin
        wr_addr_reg <= addr;
        wr_data_reg <= data_bus_bits_in;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_reg
      always_ff @(posedge sys_clk) begin
        if (!resetn) begin
          regs_reg[gi] <= `NVHBD_REG_RST;
        end else if (wr_end && ((wr_addr_reg & `NVHBD_REG_MASK) == `NVHBD_REG_BASE)
                     && wr_addr_reg[3:0] == 4'(gi)) begin
          regs_reg[gi] <= wr_data_reg;
        end
      end
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      data_bus_bits_out <= 8'h00;
      data_bus_bits_oe_n <= 1'b1;
      ext_ram_select_n <= 1'b1;
      ext_ram_read_strobe_n <= 1'b1;
      rst_out_oe_n <= 1'b0;
    end else begin
      data_bus_bits_out <= regs_reg[addr[3:0]];
      data_bus_bits_oe_n <= !reg_rd;
      ext_ram_select_n <= !sel;
      ext_ram_read_strobe_n <= !ram_rd;
      rst_out_oe_n <= powered;
    end
  end
  assign rst_out_n = 1'b0;

  // ****************************************
  // Checks on behaviour
  // ****************************************
  sequence s_fail;
    !supply_ok;
  endsequence
  sequence s_reg_rd;
    reg_rd;
  endsequence

  AST_REG_RD_NO_OE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg_rd |=> ext_ram_read_strobe_n)
    else $error("ram output enable active on register read");
  AST_RAM_RD_OE: assert property (@(posedge sys_clk) disable iff (!resetn)
    ram_rd |=> !ext_ram_read_strobe_n)
    else $error("ram output enable not following host");
  AST_WR_RELEASE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!wr_en_n && !chip_en_n) |=> data_bus_bits_oe_n)
    else $error("data bus driven during write");
  AST_FAIL_DESEL: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_fail |=> ##1 ext_ram_select_n)
    else $error("ram select active after supply fail");
  AST_FAIL_RST: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_fail |=> ##1 !rst_out_oe_n)
    else $error("reset not driven after supply fail");
  AST_REC_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_reg == NVHBD_REC) |=> ext_ram_select_n && !rst_out_oe_n)
    else $error("ram select or reset released during recovery");
  AST_REC_END: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pwr_reg == NVHBD_REC && supply_ok && rec_done) |=> powered)
    else $error("recovery did not end at count");
  AST_CE_FOLLOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    (powered && supply_ok) ##1 powered |-> ext_ram_select_n == $past(chip_en_n))
    else $error("ram select not following chip enable");
  AST_REG_WRITE: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_end && wr_addr_reg[18:4] == 15'h7FFF) |=> regs_reg[wr_addr_reg[3:0]] == $past(wr_data_reg))
    else $error("register write lost");
  AST_REG_RD_DRIVE: assert property (@(posedge sys_clk) disable iff (!resetn)
    s_reg_rd |=> !data_bus_bits_oe_n)
    else $error("register read did not drive the data bus");
  AST_RAM_RD_SEL: assert property (@(posedge sys_clk) disable iff (!resetn)
    ram_rd |=> !ext_ram_select_n && data_bus_bits_oe_n)
    else $error("external read did not select the ram");
  AST_RAM_WR_SEL: assert property (@(posedge sys_clk) disable iff (!resetn)
    (wr_cyc && !in_regs) |=> !ext_ram_select_n)
    else $error("external write did not select the ram");
  AST_OFF_NO_ACCESS: assert property (@(posedge sys_clk) disable iff (!resetn)
    !powered |=> data_bus_bits_oe_n && ext_ram_read_strobe_n)
    else $error("access allowed while supply not valid");
  AST_RST_PIN_LOW: assert property (@(posedge sys_clk) disable iff (!resetn)
    !rst_out_n)
    else $error("reset pin value not low");
  // The open-drain reset only ever pulls low; its enable alone carries the level.
  // Register reads and writes outside RUN are blocked through the select term.
endmodule : nvhbd_top
`default_nettype wire

// File: src/nvhbd_params.svh
`ifndef NVHBD_PARAMS_SVH
`define NVHBD_PARAMS_SVH
`define NVHBD_ADDR_W 19
`define NVHBD_REG_BASE 19'h7FFF0
`define NVHBD_REG_MASK 19'h7FFF0
`define NVHBD_CLK_MHZ 100
`define NVHBD_TREC_MIN_MS 40
`define NVHBD_TREC_MAX_MS 200
`define NVHBD_REC_CYCLES (`NVHBD_TREC_MIN_MS * 1000 * `NVHBD_CLK_MHZ)
`define NVHBD_REC_MAX_CYCLES (`NVHBD_TREC_MAX_MS * 1000 * `NVHBD_CLK_MHZ)
`define NVHBD_REG_RST 8'h00
`endif

// File: src/nvhbd_pkg.sv
package nvhbd_pkg;
  typedef enum logic [2:0] {
    NVHBD_OFF = 3'b001,
    NVHBD_REC = 3'b010,
    NVHBD_RUN = 3'b100
  } nvhbd_pwr_t;
endpackage : nvhbd_pkg

// File: tb/nvhbd_ram_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// External static RAM seen from its select and read strobes.
// ************************************************************
module nvhbd_ram_model (
  input wire logic ram_sel_n,
  input wire logic ram_rd_n,
  output logic ram_drv
);
  // The RAM only drives the shared data bus when selected and read enabled.
  assign ram_drv = !ram_sel_n && !ram_rd_n;
endmodule : nvhbd_ram_model
`default_nettype wire

// File: tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk, resetn, supply_ok, chip_en_n, out_en_n, wr_en_n;
  logic [18:0] addr;
  logic [7:0] din, dout;
  logic doe_n, sel_n, rd_n, rst_n, rst_oe_n, drv;
  int mismatches = 0;
  int cmp_count = 0;
  nvhbd_top #(.REC_CYCLES(20)) nvhbd_top_inst (.sys_clk(sys_clk), .resetn(resetn),
    .supply_ok(supply_ok), .chip_en_n(chip_en_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n),
    .addr(addr), .data_bus_bits_in(din), .data_bus_bits_out(dout),
    .data_bus_bits_oe_n(doe_n), .ext_ram_select_n(sel_n),
    .ext_ram_read_strobe_n(rd_n), .rst_out_n(rst_n), .rst_out_oe_n(rst_oe_n));
  nvhbd_ram_model nvhbd_ram_model_inst (.ram_sel_n(sel_n), .ram_rd_n(rd_n), .ram_drv(drv));
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Host strobes change at a falling edge; address is held for n cycles.
  task automatic bus(input logic ce, oe, we, input logic [18:0] a, input logic [7:0] d,
                     input int n);
    chip_en_n = ce;
    out_en_n = oe;
    wr_en_n = we;
    addr = a;
    din = d;
    repeat (n) @(negedge sys_clk);
  endtask : bus
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  task automatic t_power_up;
    supply_ok = 1;
    bus(0, 1, 1, 19'h00010, 8'h00, 5);
    check("rst held", {7'h00, rst_oe_n}, 8'h00);
    check("sel blocked", {7'h00, sel_n}, 8'h01);
    bus(0, 1, 1, 19'h00010, 8'h00, 25);
    check("rst released", {7'h00, rst_oe_n}, 8'h01);
    check("sel follows", {7'h00, sel_n}, 8'h00);
    bus(1, 1, 1, 19'h00010, 8'h00, 3);
    check("sel off", {7'h00, sel_n}, 8'h01);
    $display("test power up done");
  endtask : t_power_up
  task automatic t_reg_rw;
    bus(0, 1, 0, 19'h7FFF3, 8'hA5, 3);
    bus(1, 1, 1, 19'h7FFF3, 8'h00, 3);
    bus(0, 0, 1, 19'h7FFF3, 8'h00, 2);
    check("reg read", dout, 8'hA5);
    check("data drive", {7'h00, doe_n}, 8'h00);
    check("ram strobe", {7'h00, rd_n}, 8'h01);
    check("no contention", {7'h00, drv}, 8'h00);
    bus(0, 0, 0, 19'h7FFF3, 8'h3C, 2);
    check("release", {7'h00, doe_n}, 8'h01);
    bus(1, 1, 1, 19'h7FFF3, 8'h00, 3);
    bus(0, 0, 1, 19'h7FFF3, 8'h00, 2);
    check("overlap write", dout, 8'h3C);
    bus(1, 1, 1, 19'h7FFF3, 8'h00, 2);
    $display("test register done");
  endtask : t_reg_rw
  task automatic t_ext;
    bus(0, 0, 1, 19'h00010, 8'h00, 2);
    check("ext strobe", {7'h00, rd_n}, 8'h00);
    check("ext no drive", {7'h00, doe_n}, 8'h01);
    check("ram drives", {7'h00, drv}, 8'h01);
    bus(0, 1, 1, 19'h00010, 8'h00, 2);
    check("ext strobe off", {7'h00, rd_n}, 8'h01);
    bus(0, 1, 0, 19'h7FFEF, 8'h77, 2);
    check("ext write sel", {7'h00, sel_n}, 8'h00);
    check("ext write bus", {7'h00, doe_n}, 8'h01);
    supply_ok = 0;
    repeat (3) @(negedge sys_clk);
    check("fail sel", {7'h00, sel_n}, 8'h01);
    check("fail rst", {7'h00, rst_oe_n}, 8'h00);
    check("rst pin", {7'h00, rst_n}, 8'h00);
    bus(0, 1, 1, 19'h00010, 8'h00, 1);
    supply_ok = 1;
    repeat (5) @(negedge sys_clk);
    supply_ok = 0;
    repeat (3) @(negedge sys_clk);
    check("fail in recovery sel", {7'h00, sel_n}, 8'h01);
    check("fail in recovery rst", {7'h00, rst_oe_n}, 8'h00);
    $display("test external and fail done");
  endtask : t_ext
  initial begin
    resetn = 0;
    supply_ok = 0;
    bus(1, 1, 1, 19'h00000, 8'h00, 10);
    resetn = 1;
    t_power_up();
    t_reg_rw();
    t_ext();
    summarize();
  end
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule : tb
`default_nettype wire
